// ==== verilog/switch_ctl_pkg.sv ====
/*
  Constants for the switch global control register: its offset, the bit
  positions of each field, reset values and the width of the register port.
  Assumes it is compiled before every design file that names it.
*/
package switch_ctl_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;
  localparam int unsigned BYTE_W = 8;

  localparam logic [11:0] SWITCH_GLOBAL_CONTROL_OFS = 12'h32C;

  localparam int unsigned FUNDAMENTAL_RESET_TRIGGER_BIT = 0;
  localparam int unsigned HOT_RESET_TRIGGER_BIT = 1;
  localparam int unsigned RESET_HOLD_BIT = 2;
  localparam int unsigned LOCKABLE_WRITE_ENABLE_BIT = 3;
  localparam int unsigned POWER_BUDGET_VALUE_UNLOCK_BIT = 4;
  localparam int unsigned NO_LINKDOWN_WARM_RESET_BIT = 5;
  localparam int unsigned SKIP_EEPROM_ON_WARM_RESET_BIT = 6;
  localparam int unsigned STRICT_ORDERING_FORCE_BIT = 7;
  localparam int unsigned PEER_TRAFFIC_BLOCK_BIT = 8;
  localparam int unsigned STORE_FORWARD_FORCE_BIT = 14;
  localparam int unsigned LOCKED_TX_PASSTHROUGH_BIT = 15;
  localparam int unsigned WAKE_PIN_DIRECTION_BIT = 16;
  localparam int unsigned AUX_POWER_USE_ENABLE_BIT = 17;
  localparam int unsigned VENDOR_BROADCAST_DROP_BIT = 18;

  localparam logic FIELD_RESET_VAL = 1'h0;
  localparam logic WAKE_DIR_INPUT = 1'h0;
  localparam logic WAKE_DIR_OUTPUT = 1'h1;

  localparam logic [31:0] READ_ZERO = 32'h00000000;

  // Pins sampled through the synchroniser: strap, auxiliary disable and wake.
  localparam int unsigned PIN_SYNC_W = 3;
  localparam int unsigned PIN_STRAP_IDX = 0;
  localparam int unsigned PIN_AUX_DIS_IDX = 1;
  localparam int unsigned PIN_WAKE_IDX = 2;

  // Cycles after power-on release before the synchronised pins are valid.
  localparam logic [1:0] POR_SETTLE_CYCLES = 2'h2;

endpackage

// ==== verilog/pin_sync_2ff.sv ====
/*
  Two flip-flop synchroniser for a small group of level inputs.
  Assumes the inputs are asynchronous levels that stay put for several clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync_2ff #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
    end
  end

  assign sync_out = stage2_q;

endmodule
`default_nettype wire

// ==== verilog/switch_global_control_register.sv ====
/*
  Switch global control register of a multi-port packet switch: reset
  triggers, the reset hold, write unlocks, routing and ordering controls,
  wake pin direction and the auxiliary power enable.
  Assumes a reset sequencer on the same clock that reports when a reset
  operation runs, and a configuration or management serial master that
  drives the register port. rst is the power-on (auxiliary power) reset.
*/
// Summary of operation
// - Writing one to bit 0 pulses a fundamental reset start; reads zero.
// - Writing one to bit 1 pulses a hot reset start; reads zero.
// - While reset hold is set, the core except management stays in reset.
// - An EEPROM initialisation error sets the reset hold bit.
// - Reset hold acts only within a reset operation; strap loads it.
// - The unlock bit gates writes to every lockable field.
// - The unlock bit resets clear and is set during each reset operation.
// - Bit 4 makes the per-port power budget value registers writable.
// - Bit 5 stops upstream link down from causing a hot reset.
// - Bit 6 skips EEPROM initialisation within the hot reset sequence.
// - Bit 7 forces strong ordering regardless of relaxed ordering.
// - Bit 8 blocks peer traffic, downstream non-upstream becomes unsupported.
// - Bit 14 forces store-and-forward routing; clear allows cut-through.
// - Bit 15 routes locked transactions as ordinary packets.
// - Bit 16 sets wake pin direction; clears on auxiliary power on.
// - Bit 17 enables auxiliary power; power-on loads inverse of pin.
// - Bit 18 drops vendor broadcast messages from the upstream port.
`timescale 1ns/1ps
`default_nettype none
module switch_global_control_register (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  input wire logic reset_in_progress,
  input wire logic fund_reset_active,
  input wire logic eeprom_init_error,
  input wire logic upstream_dl_down,
  input wire logic hot_reset_other,
  input wire logic reset_hold_strap,
  input wire logic aux_power_disable_pin_n,
  input wire logic wake_pin_n_i,
  output logic wake_pin_n_o,
  output logic wake_pin_n_oe,
  input wire logic wake_request,
  output logic wake_detect,
  output logic fundamental_reset_start,
  output logic hot_reset_start,
  output logic core_hold,
  output logic lockable_write_enable,
  output logic power_budget_value_unlock,
  output logic no_linkdown_warm_reset,
  output logic skip_eeprom_on_warm_reset,
  output logic strict_ordering_force,
  output logic peer_traffic_block,
  output logic store_forward_force,
  output logic locked_tx_passthrough,
  output logic wake_pin_direction,
  output logic aux_power_use_enable,
  output logic vendor_broadcast_drop
);

  //////////////////////////////////////////////////////////////////////////////

  logic [2:0] pin_async;
  logic [2:0] pin_sync;
  logic strap_s;
  logic aux_dis_n_s;
  logic wake_in_s;

  assign pin_async = {~wake_pin_n_i, aux_power_disable_pin_n,
    reset_hold_strap};

  pin_sync_2ff #(
    .WIDTH(switch_ctl_pkg::PIN_SYNC_W)
  ) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .async_in(pin_async),
    .sync_out(pin_sync)
  );

  assign strap_s = pin_sync[switch_ctl_pkg::PIN_STRAP_IDX];
  assign aux_dis_n_s = pin_sync[switch_ctl_pkg::PIN_AUX_DIS_IDX];
  assign wake_in_s = pin_sync[switch_ctl_pkg::PIN_WAKE_IDX];

  //////////////////////////////////////////////////////////////////////////////

  logic hit;
  logic [31:0] be_mask;
  logic [31:0] wen;
  logic [31:0] wset;

  assign hit = (cfg_addr == switch_ctl_pkg::SWITCH_GLOBAL_CONTROL_OFS);

  // Each byte enable opens its own eight bits of the word.
  genvar gb;
  generate
    for (gb = 0; gb < switch_ctl_pkg::BE_W; gb++) begin : g_be
      assign be_mask[gb*switch_ctl_pkg::BYTE_W +: switch_ctl_pkg::BYTE_W] =
        {switch_ctl_pkg::BYTE_W{cfg_be[gb]}};
    end
  endgenerate

  assign wen = {32{cfg_wr & hit}} & be_mask;
  assign wset = wen & cfg_wdata;

  //////////////////////////////////////////////////////////////////////////////

  // Power-on settle counter: the pin synchroniser needs two clocks to fill.
  logic [1:0] por_cnt_q;
  logic por_load;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      por_cnt_q <= 2'h0;
    end else if (por_cnt_q != (switch_ctl_pkg::POR_SETTLE_CYCLES + 2'h1)) begin
      por_cnt_q <= por_cnt_q + 2'h1;
    end
  end

  assign por_load = (por_cnt_q == switch_ctl_pkg::POR_SETTLE_CYCLES);

  //////////////////////////////////////////////////////////////////////////////

  logic fund_start_q;
  logic hot_start_q;
  logic no_linkdown_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fund_start_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else begin
      fund_start_q <= wset[switch_ctl_pkg::FUNDAMENTAL_RESET_TRIGGER_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hot_start_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else begin
      hot_start_q <= wset[switch_ctl_pkg::HOT_RESET_TRIGGER_BIT] |
        hot_reset_other | (upstream_dl_down & ~no_linkdown_q);
    end
  end

  assign fundamental_reset_start = fund_start_q;
  assign hot_reset_start = hot_start_q;

  //////////////////////////////////////////////////////////////////////////////

  logic reset_hold_q;
  logic hold_window_q;

  // The strap is caught during a fundamental reset, then writes and an
  // EEPROM error may change it; the error wins over a clearing write.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_hold_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (por_load | fund_reset_active) begin
      reset_hold_q <= strap_s;
    end else if (eeprom_init_error) begin
      reset_hold_q <= 1'h1;
    end else if (wen[switch_ctl_pkg::RESET_HOLD_BIT]) begin
      reset_hold_q <= cfg_wdata[switch_ctl_pkg::RESET_HOLD_BIT];
    end
  end

  // The hold window opens with a reset operation and closes once the core
  // is released, so setting the bit afterwards cannot stall a live switch.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_window_q <= 1'h1;
    end else if (reset_in_progress | por_load) begin
      hold_window_q <= 1'h1;
    end else if (!reset_hold_q) begin
      hold_window_q <= 1'h0;
    end
  end

  assign core_hold = reset_hold_q & hold_window_q;

  //////////////////////////////////////////////////////////////////////////////

  logic unlock_q;

  // A reset operation sets the unlock; it wins over a clearing write.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unlock_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (reset_in_progress) begin
      unlock_q <= 1'h1;
    end else if (wen[switch_ctl_pkg::LOCKABLE_WRITE_ENABLE_BIT]) begin
      unlock_q <= cfg_wdata[switch_ctl_pkg::LOCKABLE_WRITE_ENABLE_BIT];
    end
  end

  assign lockable_write_enable = unlock_q;

  logic pb_unlock_q;

  // This field is itself lockable, so the unlock gates its writes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pb_unlock_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (fund_reset_active) begin
      pb_unlock_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (wen[switch_ctl_pkg::POWER_BUDGET_VALUE_UNLOCK_BIT] &
                 unlock_q) begin
      pb_unlock_q <= cfg_wdata[switch_ctl_pkg::POWER_BUDGET_VALUE_UNLOCK_BIT];
    end
  end

  assign power_budget_value_unlock = pb_unlock_q;

  //////////////////////////////////////////////////////////////////////////////

  // Plain sticky controls: kept over a hot reset, cleared by fundamental.
  logic skip_eeprom_q;
  logic strict_order_q;
  logic peer_block_q;
  logic store_fwd_q;
  logic lock_pass_q;
  logic bcast_drop_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      no_linkdown_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (fund_reset_active) begin
      no_linkdown_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (wen[switch_ctl_pkg::NO_LINKDOWN_WARM_RESET_BIT]) begin
      no_linkdown_q <= cfg_wdata[switch_ctl_pkg::NO_LINKDOWN_WARM_RESET_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      skip_eeprom_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (fund_reset_active) begin
      skip_eeprom_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (wen[switch_ctl_pkg::SKIP_EEPROM_ON_WARM_RESET_BIT]) begin
      skip_eeprom_q <=
        cfg_wdata[switch_ctl_pkg::SKIP_EEPROM_ON_WARM_RESET_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strict_order_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (fund_reset_active) begin
      strict_order_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (wen[switch_ctl_pkg::STRICT_ORDERING_FORCE_BIT]) begin
      strict_order_q <= cfg_wdata[switch_ctl_pkg::STRICT_ORDERING_FORCE_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      peer_block_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (fund_reset_active) begin
      peer_block_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (wen[switch_ctl_pkg::PEER_TRAFFIC_BLOCK_BIT]) begin
      peer_block_q <= cfg_wdata[switch_ctl_pkg::PEER_TRAFFIC_BLOCK_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      store_fwd_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (fund_reset_active) begin
      store_fwd_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (wen[switch_ctl_pkg::STORE_FORWARD_FORCE_BIT]) begin
      store_fwd_q <= cfg_wdata[switch_ctl_pkg::STORE_FORWARD_FORCE_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_pass_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (fund_reset_active) begin
      lock_pass_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (wen[switch_ctl_pkg::LOCKED_TX_PASSTHROUGH_BIT]) begin
      lock_pass_q <= cfg_wdata[switch_ctl_pkg::LOCKED_TX_PASSTHROUGH_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bcast_drop_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (fund_reset_active) begin
      bcast_drop_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (wen[switch_ctl_pkg::VENDOR_BROADCAST_DROP_BIT]) begin
      bcast_drop_q <= cfg_wdata[switch_ctl_pkg::VENDOR_BROADCAST_DROP_BIT];
    end
  end

  assign no_linkdown_warm_reset = no_linkdown_q;
  assign skip_eeprom_on_warm_reset = skip_eeprom_q;
  assign strict_ordering_force = strict_order_q;
  assign peer_traffic_block = peer_block_q;
  assign store_forward_force = store_fwd_q;
  assign locked_tx_passthrough = lock_pass_q;
  assign vendor_broadcast_drop = bcast_drop_q;

  //////////////////////////////////////////////////////////////////////////////

  // Auxiliary power fields survive a fundamental reset; only power-on
  // returns them to their initial values.
  logic wake_dir_q;
  logic aux_en_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_dir_q <= switch_ctl_pkg::WAKE_DIR_INPUT;
    end else if (wen[switch_ctl_pkg::WAKE_PIN_DIRECTION_BIT]) begin
      wake_dir_q <= cfg_wdata[switch_ctl_pkg::WAKE_PIN_DIRECTION_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aux_en_q <= switch_ctl_pkg::FIELD_RESET_VAL;
    end else if (por_load) begin
      aux_en_q <= ~aux_dis_n_s;
    end else if (wen[switch_ctl_pkg::AUX_POWER_USE_ENABLE_BIT]) begin
      aux_en_q <= cfg_wdata[switch_ctl_pkg::AUX_POWER_USE_ENABLE_BIT];
    end
  end

  assign wake_pin_direction = wake_dir_q;
  assign aux_power_use_enable = aux_en_q;

  // The wake pin is active low; its input is synced inverted, so reset is idle.
  logic wake_out_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_out_q <= 1'h0;
    end else begin
      wake_out_q <= wake_request & (wake_dir_q ==
        switch_ctl_pkg::WAKE_DIR_OUTPUT);
    end
  end

  assign wake_pin_n_o = ~wake_out_q;
  assign wake_pin_n_oe = (wake_dir_q == switch_ctl_pkg::WAKE_DIR_OUTPUT);
  assign wake_detect = wake_in_s & (wake_dir_q ==
    switch_ctl_pkg::WAKE_DIR_INPUT);

  //////////////////////////////////////////////////////////////////////////////

  logic [31:0] read_word;
  logic [31:0] rdata_q;
  logic ack_q;

  always_comb begin
    read_word = switch_ctl_pkg::READ_ZERO;
    read_word[switch_ctl_pkg::FUNDAMENTAL_RESET_TRIGGER_BIT] = 1'h0;
    read_word[switch_ctl_pkg::HOT_RESET_TRIGGER_BIT] = 1'h0;
    read_word[switch_ctl_pkg::RESET_HOLD_BIT] = reset_hold_q;
    read_word[switch_ctl_pkg::LOCKABLE_WRITE_ENABLE_BIT] = unlock_q;
    read_word[switch_ctl_pkg::POWER_BUDGET_VALUE_UNLOCK_BIT] = pb_unlock_q;
    read_word[switch_ctl_pkg::NO_LINKDOWN_WARM_RESET_BIT] = no_linkdown_q;
    read_word[switch_ctl_pkg::SKIP_EEPROM_ON_WARM_RESET_BIT] = skip_eeprom_q;
    read_word[switch_ctl_pkg::STRICT_ORDERING_FORCE_BIT] = strict_order_q;
    read_word[switch_ctl_pkg::PEER_TRAFFIC_BLOCK_BIT] = peer_block_q;
    read_word[switch_ctl_pkg::STORE_FORWARD_FORCE_BIT] = store_fwd_q;
    read_word[switch_ctl_pkg::LOCKED_TX_PASSTHROUGH_BIT] = lock_pass_q;
    read_word[switch_ctl_pkg::WAKE_PIN_DIRECTION_BIT] = wake_dir_q;
    read_word[switch_ctl_pkg::AUX_POWER_USE_ENABLE_BIT] = aux_en_q;
    read_word[switch_ctl_pkg::VENDOR_BROADCAST_DROP_BIT] = bcast_drop_q;
  end

  // Every access is acknowledged one clock later; an unmapped read gets zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= switch_ctl_pkg::READ_ZERO;
      ack_q <= 1'h0;
    end else begin
      ack_q <= cfg_wr | cfg_rd;
      if (cfg_rd) begin
        rdata_q <= hit ? read_word : switch_ctl_pkg::READ_ZERO;
      end
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg_ack = ack_q;

endmodule
`default_nettype wire

// ==== bench/switch_global_control_register_chk.sv ====
/*
  Assertions on the ports of the switch global control register.
  Assumes one clock and the active-high power-on reset rst.
*/
`timescale 1ns/1ps
`default_nettype none
module switch_global_control_register_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack,
  input wire logic reset_in_progress,
  input wire logic fund_reset_active,
  input wire logic eeprom_init_error,
  input wire logic upstream_dl_down,
  input wire logic hot_reset_other,
  input wire logic wake_pin_n_oe,
  input wire logic wake_detect,
  input wire logic fundamental_reset_start,
  input wire logic hot_reset_start,
  input wire logic core_hold,
  input wire logic lockable_write_enable,
  input wire logic power_budget_value_unlock,
  input wire logic no_linkdown_warm_reset,
  input wire logic peer_traffic_block,
  input wire logic store_forward_force,
  input wire logic locked_tx_passthrough,
  input wire logic wake_pin_direction
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire logic hit = cfg_wr &&
    cfg_addr == switch_ctl_pkg::SWITCH_GLOBAL_CONTROL_OFS;
  wire logic hit0 = hit && cfg_be[0];
  ////////////////////////////////////////
  chk_ack_follows:
    assert property (cfg_ack == $past(cfg_wr || cfg_rd))
    else $error("ack does not follow the access");
  chk_fund_pulse:
    assert property (fundamental_reset_start == $past(hit0 && cfg_wdata[0]))
    else $error("fundamental reset pulse wrong");
  chk_hot_pulse:
    assert property (hot_reset_start == $past(hot_reset_other ||
      hit0 && cfg_wdata[1] || upstream_dl_down && !no_linkdown_warm_reset))
    else $error("hot reset pulse wrong");
  chk_reserved_zero:
    assert property (cfg_rd |=> (cfg_rdata & 32'hFFF83E03) == 32'h0)
    else $error("reserved or trigger bits read nonzero");
  chk_unmapped_zero:
    assert property (cfg_rd && cfg_addr !=
      switch_ctl_pkg::SWITCH_GLOBAL_CONTROL_OFS |=> cfg_rdata == 32'h0)
    else $error("unmapped read nonzero");
  chk_lock_gate:
    assert property (!lockable_write_enable && !fund_reset_active
      |=> $stable(power_budget_value_unlock))
    else $error("locked field changed");
  chk_unlock_set:
    assert property (reset_in_progress |=> lockable_write_enable)
    else $error("unlock not set during reset");
  chk_eeprom_hold:
    assert property (eeprom_init_error && reset_in_progress &&
      !fund_reset_active |=> core_hold)
    else $error("eeprom error did not hold core");
  chk_hold_release:
    assert property (core_hold && !reset_in_progress && !fund_reset_active
      && !eeprom_init_error && hit0 && !cfg_wdata[2] |=> !core_hold)
    else $error("core hold not released");
  chk_byte_one:
    assert property (hit && cfg_be[1] && !fund_reset_active
      |=> {peer_traffic_block, store_forward_force, locked_tx_passthrough}
      == $past({cfg_wdata[8], cfg_wdata[14], cfg_wdata[15]}))
    else $error("byte one fields not written");
  chk_wake_dir:
    assert property (wake_pin_n_oe == wake_pin_direction &&
      !(wake_detect && wake_pin_direction))
    else $error("wake direction wrong");
endmodule
bind switch_global_control_register switch_global_control_register_chk
  i_chk (.clk, .rst, .cfg_addr, .cfg_wr, .cfg_rd, .cfg_be, .cfg_wdata,
  .cfg_rdata, .cfg_ack, .reset_in_progress, .fund_reset_active,
  .eeprom_init_error, .upstream_dl_down, .hot_reset_other, .wake_pin_n_oe,
  .wake_detect, .fundamental_reset_start, .hot_reset_start, .core_hold,
  .lockable_write_enable, .power_budget_value_unlock,
  .no_linkdown_warm_reset, .peer_traffic_block, .store_forward_force,
  .locked_tx_passthrough, .wake_pin_direction);
`default_nettype wire

// ==== bench/reset_seq_model.sv ====
/*
  Reset sequencer model: runs a reset operation after each start pulse seen while idle.
  Assumes the register block's clock and power-on reset.
*/
`timescale 1ns/1ps
`default_nettype none
module reset_seq_model #(
  parameter int unsigned SEQ_LEN = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic fundamental_reset_start,
  input wire logic hot_reset_start,
  output logic reset_in_progress,
  output logic fund_reset_active
);
  int unsigned cnt_q;
  logic fund_q;
  assign reset_in_progress = cnt_q != 0;
  // The fundamental phase covers the first half of the operation.
  assign fund_reset_active = fund_q && cnt_q > SEQ_LEN / 2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 0;
      fund_q <= 1'b0;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end else if (fundamental_reset_start || hot_reset_start) begin
      cnt_q <= SEQ_LEN;
      fund_q <= fundamental_reset_start;
    end
  end
endmodule
`default_nettype wire

// ==== bench/switch_global_control_register_tb_top.sv ====
/*
  Self-checking bench for the switch global control register.
  Assumes the sequencer model and the bound checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module switch_global_control_register_tb_top;
  localparam logic [11:0] REG_OFS = switch_ctl_pkg::SWITCH_GLOBAL_CONTROL_OFS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] cfg_addr = 12'h000;
  logic cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, m, f;
  logic eeprom_init_error = 1'b0, upstream_dl_down = 1'b0;
  logic hot_reset_other = 1'b0, reset_hold_strap = 1'b0;
  logic aux_power_disable_pin_n = 1'b1, wake_ext_n = 1'b1;
  logic wake_request = 1'b0, aux_n;
  logic cfg_ack, wake_pin_n_o, wake_pin_n_oe, wake_detect, core_hold;
  logic fundamental_reset_start, hot_reset_start, lockable_write_enable;
  logic power_budget_value_unlock, no_linkdown_warm_reset;
  logic skip_eeprom_on_warm_reset, strict_ordering_force, peer_traffic_block;
  logic store_forward_force, locked_tx_passthrough, wake_pin_direction;
  logic aux_power_use_enable, vendor_broadcast_drop;
  logic reset_in_progress, fund_reset_active;
  logic [11:0] a;
  int num_errors = 0;
  int total_checks = 0;
  // The wake line is pulled up; either party may pull it low.
  wire logic wake_wire = (wake_pin_n_oe && !wake_pin_n_o) ? 1'b0 : wake_ext_n;
  always #25 clk = ~clk;
  switch_global_control_register i_dut (.clk, .rst, .cfg_addr, .cfg_wr,
    .cfg_rd, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .reset_in_progress,
    .fund_reset_active, .eeprom_init_error, .upstream_dl_down,
    .hot_reset_other, .reset_hold_strap, .aux_power_disable_pin_n,
    .wake_pin_n_i(wake_wire), .wake_pin_n_o, .wake_pin_n_oe, .wake_request,
    .wake_detect, .fundamental_reset_start, .hot_reset_start, .core_hold,
    .lockable_write_enable, .power_budget_value_unlock,
    .no_linkdown_warm_reset, .skip_eeprom_on_warm_reset,
    .strict_ordering_force, .peer_traffic_block, .store_forward_force,
    .locked_tx_passthrough, .wake_pin_direction, .aux_power_use_enable,
    .vendor_broadcast_drop);
  reset_seq_model i_seq (.clk, .rst, .fundamental_reset_start,
    .hot_reset_start, .reset_in_progress, .fund_reset_active);
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic do_por(input logic strap, input logic pin_n);
    @(posedge clk);
    rst <= 1'b1;
    reset_hold_strap <= strap;
    aux_power_disable_pin_n <= pin_n;
    repeat (10) @(posedge clk);
    #1;
    check(32'({wake_pin_n_o, wake_pin_n_oe, core_hold, cfg_ack}), 32'h8);
    @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    m = {14'h0, !pin_n, 14'h0, strap, 2'h0};
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d,
    input logic [3:0] be);
    logic [31:0] bm;
    logic [31:0] wm;
    logic [1:0] pe;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    // bit 4 lands only while unlocked.
    wm = m[3] ? 32'h0007C1FC : 32'h0007C1EC;
    pe = (ad == REG_OFS && be[0]) ? d[1:0] : 2'h0;
    @(posedge clk);
    cfg_addr <= ad;
    cfg_be <= be;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    if (ad == REG_OFS) m = (m & ~(wm & bm)) | (d & wm & bm);
    #1;
    check(32'(cfg_ack), 32'h1);
    check(32'({fundamental_reset_start, hot_reset_start}), 32'({pe[0], pe[1]}));
    f = 32'({vendor_broadcast_drop, aux_power_use_enable,
      wake_pin_direction, locked_tx_passthrough, store_forward_force, 5'h0,
      peer_traffic_block, strict_ordering_force, skip_eeprom_on_warm_reset,
      no_linkdown_warm_reset, power_budget_value_unlock,
      lockable_write_enable, 3'h0});
    check(f, m & 32'h0007C1F8);
  endtask
  task automatic rd(input logic [11:0] ad);
    @(posedge clk);
    cfg_addr <= ad;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    check(32'(cfg_ack), 32'h1);
    check(cfg_rdata, ad == REG_OFS ? m & 32'h0007C1FC : 32'h0);
  endtask
  task automatic wait_seq();
    repeat (2) @(posedge clk);
    for (int n = 0; reset_in_progress !== 1'b0; n++) begin
      if (n == 40) begin
        num_errors++;
        give_verdict();
      end
      @(posedge clk);
    end
    // each reset operation leaves the unlock set.
    m[3] = 1'b1;
  endtask
  task automatic pulse(input logic link, input logic exp);
    @(posedge clk);
    upstream_dl_down <= link;
    hot_reset_other <= !link;
    @(posedge clk);
    upstream_dl_down <= 1'b0;
    hot_reset_other <= 1'b0;
    #1;
    check(32'(hot_reset_start), 32'(exp));
    if (exp) wait_seq();
  endtask
  task automatic release_hold();
    wr(REG_OFS, m & 32'hFFFFFFFB, 4'h1);
    check(32'(core_hold), 32'h0);
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h98C4));
    aux_n = 1'($urandom);
    do_por(1'b0, aux_n);
    rd(REG_OFS);
    repeat (24) begin
      a = ($urandom % 4 == 0) ? REG_OFS + 12'h004 : REG_OFS;
      wr(a, $urandom & 32'hFFFFFFFC, 4'($urandom));
      rd(a);
      rd(REG_OFS);
      check(32'(core_hold), 32'h0);
    end
    wr(REG_OFS, 32'h0, 4'h1);
    pulse(1'b1, 1'b1);
    wr(REG_OFS, 32'h20, 4'h1);
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    rd(REG_OFS);
    wr(REG_OFS, 32'h2, 4'h1);
    repeat (3) @(posedge clk);
    eeprom_init_error <= 1'b1;
    @(posedge clk);
    eeprom_init_error <= 1'b0;
    m[2] = 1'b1;
    wait_seq();
    check(32'(core_hold), 32'h1);
    rd(REG_OFS);
    release_hold();
    @(posedge clk);
    reset_hold_strap <= 1'b1;
    wr(REG_OFS, m | 32'h1, 4'h1);
    wait_seq();
    // fundamental reset clears sticky fields and reloads the hold.
    m = (m & 32'h00030000) | 32'h0000000C;
    check(32'(core_hold), 32'h1);
    rd(REG_OFS);
    release_hold();
    wr(REG_OFS, m | 32'h4, 4'h1);
    check(32'(core_hold), 32'h0);
    wr(REG_OFS, 32'h0, 4'h4);
    @(posedge clk);
    wake_ext_n <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(32'(wake_detect), 32'h1);
    @(posedge clk);
    wake_ext_n <= 1'b1;
    wake_request <= 1'b1;
    wr(REG_OFS, 32'h00010000, 4'h4);
    repeat (4) @(posedge clk);
    #1;
    check(32'({wake_pin_n_oe, wake_pin_n_o, wake_detect}), 32'h4);
    do_por(1'b1, !aux_n);
    rd(REG_OFS);
    check(32'(core_hold), 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
